// ===== core/spi_mode_pkg.sv
package spi_mode_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0]  ADDR_MAIN_CTRL   = 8'h00;  // Mode, disable, loop fields
   localparam logic [7:0]  ADDR_FRAME_CNT   = 8'h04;  // Frames to receive minus one
   localparam logic [7:0]  ADDR_ENABLE      = 8'h08;  // Controller enable
   localparam logic [7:0]  ADDR_DATA        = 8'h0C;  // Tx write only; reads are refused with pslverr
   localparam logic [7:0]  ADDR_STATUS      = 8'h10;  // Status readback

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int          POS_LOOP         = 11;
   localparam int          POS_TXD_DIS      = 10;
   localparam int          POS_MODE_LO      = 8;
   localparam int          POS_MASTER       = 0;     // Role select is bit POS_MASTER + 1 of enable reg
   localparam logic        RST_LOOP         = 1'h0;
   localparam logic        RST_TXD_DIS      = 1'h0;
   localparam logic [1:0]  RST_MODE         = 2'h0;
   localparam logic [15:0] RST_FRAME_CNT    = 16'h0000;
   localparam logic [31:0] RD_UNMAPPED      = 32'h0000_0000;

   // ------------------------------------------------------------
   // Transfer modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_TXRX = 2'b00,
      MODE_TX   = 2'b01,
      MODE_RX   = 2'b10,
      MODE_EEP  = 2'b11
   } xfer_mode_t;

   // Frame width on the wire
   localparam int          FRAME_BITS       = 8;
   // Serial clock divider for master role: toggle every SCLK_HALF + 1 pclk
   localparam logic [7:0]  SCLK_HALF        = 8'h04;

   // Control bundle
   typedef struct packed {
      logic       loop_test_select;
      logic       slave_txd_disable;
      xfer_mode_t transfer_mode_select;
   } ctrl_t;

endpackage : spi_mode_pkg

// ===== core/spi_transfer_mode_control.sv
// Operation
// - Loop bit: 0 normal, 1 test
// - Test mode routes tx shift into rx
// - Txd disable acts only in slave role
// - Disable set: output enable never asserted
// - Txd disable resets to zero
// - Mode field bits 9:8, resets 00
// - Shifting always full duplex
// - Tx-only drops received frames
// - Rx-only resends first written word
// - Tx/rx runs until tx FIFO empty
// - Tx/rx stores each received frame; code drops a frame when the two-entry rx buffer is full
// - EEPROM mode: tx entries are control
// - EEPROM: rx valid after control done
// - EEPROM mode only as master; code also runs it in slave role
// - Master rx count reaches count plus one
// - Slave rx-only runs while selected
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module spi_transfer_mode_control
   import spi_mode_pkg::*;
#(
   parameter int FIFO_DEPTH = 4
) (
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial link pins
   input  wire logic        sclk_in,
   input  wire logic        ss_in_n,
   input  wire logic        rxd,
   output logic             sclk_out,
   output logic             ss_out_n,
   output logic             txd,
   output logic             txd_oe_n,
   // Received word stream
   output logic [7:0]       rx_data,
   output logic             rx_valid,
   input  wire logic        rx_ready
);

   // ------------------------------------------------------------
   // State and registers
   // ------------------------------------------------------------
   typedef enum {ST_IDLE, ST_XFER, ST_TAIL} st_t;

   ctrl_t       ctrl_q,   ctrl_d;     // Lockable control fields
   logic [15:0] fcnt_q,   fcnt_d;     // frame_count_minus_one
   logic        en_q,     en_d;       // Controller enable
   logic        mst_q,    mst_d;      // 1 = master role
   logic [7:0]  txf_q [FIFO_DEPTH];   // Tx FIFO storage
   logic [7:0]  txf_d [FIFO_DEPTH];
   logic [2:0]  tcnt_q,   tcnt_d;     // Tx FIFO fill level
   logic [7:0]  rword_q,  rword_d;    // Word repeated in rx-only
   logic [7:0]  sh_tx_q,  sh_tx_d;    // Transmit shift register
   logic [7:0]  sh_rx_q,  sh_rx_d;    // Receive shift register
   logic [2:0]  bit_q,    bit_d;      // Bit counter in frame
   logic [15:0] rxn_q,    rxn_d;      // Frames received
   logic [7:0]  div_q,    div_d;      // Master clock divider
   logic        sck_q,    sck_d;      // Master clock level
   logic        ssn_q,    ssn_d;      // Master select level
   logic        oen_q,    oen_d;      // Registered txd enable, low active
   logic        ctlf_q,   ctlf_d;     // Frame in flight carries control data
   st_t         st_q,     st_d;
   logic [31:0] prd_q,    prd_d;
   logic        prdy_q,   prdy_d;
   logic        perr_q,   perr_d;
   // Two-entry skid buffer toward the rx consumer
   logic [7:0]  buf_q [2];
   logic [7:0]  buf_d [2];
   logic [1:0]  bcnt_q,   bcnt_d;

   // Two-flop synchronisers for pins
   logic [2:0] s1_q, s2_q;
   logic       sck_prev_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Idle pin levels: clock low, select high, data low
         s1_q       <= 3'h2;
         s2_q       <= 3'h2;
         sck_prev_q <= 1'b0;
      end else begin
         s1_q       <= {sclk_in, ss_in_n, rxd};
         s2_q       <= s1_q;
         sck_prev_q <= s2_q[2];
      end
   end

   logic sck_s, ssn_s, rxd_s;
   assign sck_s = s2_q[2];
   assign ssn_s = s2_q[1];
   assign rxd_s = s2_q[0];

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      logic       wr, rd, rise, fall, done, rx_ok, last, bit_in, push;
      logic [7:0] rxw;
      ctrl_d  = ctrl_q;
      fcnt_d  = fcnt_q;
      en_d    = en_q;
      mst_d   = mst_q;
      txf_d   = txf_q;
      tcnt_d  = tcnt_q;
      rword_d = rword_q;
      sh_tx_d = sh_tx_q;
      sh_rx_d = sh_rx_q;
      bit_d   = bit_q;
      rxn_d   = rxn_q;
      div_d   = div_q;
      sck_d   = sck_q;
      ssn_d   = ssn_q;
      st_d    = st_q;
      ctlf_d  = ctlf_q;
      rise    = 1'b0;
      fall    = 1'b0;
      bit_in  = 1'b0;
      buf_d   = buf_q;
      bcnt_d  = bcnt_q;
      prd_d   = prd_q;
      perr_d  = 1'b0;
      push    = 1'b0;
      rxw     = 8'h00;
      rx_ok   = 1'b0;
      done    = 1'b0;
      last    = 1'b0;
      wr      = psel && penable && pwrite && !prdy_q;
      rd      = psel && penable && !pwrite && !prdy_q;
      prdy_d  = psel && penable && !prdy_q;

      // Output consumer drains front entry
      if (bcnt_q != 2'd0 && rx_ready) begin
         buf_d[0] = buf_q[1];
         bcnt_d   = bcnt_q - 2'd1;
      end

      // Edge detect: master uses own divider, slave the sampled clock
      if (mst_q) begin
         // Tail state keeps the divider so the last high phase completes
         if (st_q != ST_IDLE) begin
            if (div_q == SCLK_HALF) begin
               div_d = 8'h00;
               sck_d = !sck_q;
               rise  = !sck_q;
               fall  = sck_q;
            end else begin
               div_d = div_q + 8'h01;
            end
         end
      end else begin
         rise = !ssn_s && sck_s && !sck_prev_q;
         fall = !ssn_s && !sck_s && sck_prev_q;
      end

      bit_in = ctrl_q.loop_test_select ? sh_tx_q[7] : rxd_s;

      // Valid-data rules per mode
      case (ctrl_q.transfer_mode_select)
         MODE_TX:   rx_ok = 1'b0;
         MODE_TXRX: rx_ok = 1'b1;
         MODE_RX:   rx_ok = 1'b1;
         default:   rx_ok = !ctlf_q;
      endcase

      // shift on every edge regardless of mode
      if (rise) begin
         sh_rx_d = {sh_rx_q[6:0], bit_in};
         bit_d   = bit_q + 3'd1;
         last    = (bit_q == 3'(FRAME_BITS - 1));
      end
      if (fall && bit_q != 3'd0) begin
         sh_tx_d = {sh_tx_q[6:0], 1'b0};
      end else if (fall && st_q != ST_TAIL) begin
         // Next word loads on the fall after a frame, never on the
         // rising edge at which the peer samples the last bit
         case (ctrl_q.transfer_mode_select)
            MODE_RX: sh_tx_d = rword_q;
            default: begin
               // every FIFO entry is control data
               ctlf_d = (tcnt_q != 3'd0);
               if (tcnt_q != 3'd0) begin
                  sh_tx_d = txf_q[0];
                  for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                     txf_d[i] = txf_q[i+1];
                  end
                  tcnt_d = tcnt_q - 3'd1;
               end
            end
         endcase
      end

      if (last) begin
         rxw = {sh_rx_q[6:0], bit_in};
         // Full buffer drops the frame; consumer must keep up
         if (rx_ok && bcnt_d != 2'd2) begin
            push = 1'b1;
            buf_d[bcnt_d[0]] = rxw;
            bcnt_d = bcnt_d + 2'd1;
         end
         if (rx_ok) begin
            rxn_d = rxn_q + 16'h0001;
         end
         // end on empty tx FIFO; end on frame count
         if (ctrl_q.transfer_mode_select == MODE_TXRX ||
             ctrl_q.transfer_mode_select == MODE_TX) begin
            done = (tcnt_q == 3'd0);
         end else begin
            done = rx_ok && (rxn_q == fcnt_q);
         end
      end

      // Master sequencing
      case (st_q)
         ST_IDLE: begin
            // Slave keeps counting while selected
            if (mst_q || ssn_s) begin
               rxn_d = 16'h0000;
               bit_d = 3'd0;
            end
            // Master start gate for every mode; EEPROM mode still shifts and stores in slave role
            if (en_q && mst_q && tcnt_q != 3'd0) begin
               st_d    = ST_XFER;
               ssn_d   = 1'b0;
               sck_d   = 1'b0;
               div_d   = 8'h00;
               sh_tx_d = txf_q[0];
               rword_d = txf_q[0];
               ctlf_d  = 1'b1;
               for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                  txf_d[i] = txf_q[i+1];
               end
               tcnt_d = tcnt_q - 3'd1;
            end else if (!mst_q && ssn_s) begin
               sh_tx_d = (tcnt_q != 3'd0) ? txf_q[0] : rword_q;
            end
         end
         ST_XFER: begin
            // Cut frame ends at once; a finished one waits for its last fall
            if (!en_q) begin
               st_d  = ST_IDLE;
               ssn_d = 1'b1;
               sck_d = 1'b0;
            end else if (done) begin
               st_d = ST_TAIL;
            end
         end
         default: begin
            if (fall || !en_q) begin
               st_d  = ST_IDLE;
               ssn_d = 1'b1;
               sck_d = 1'b0;
            end
         end
      endcase

      // APB register writes; control, frame count and role locked while enabled
      if (wr) begin
         if (paddr == ADDR_MAIN_CTRL) begin
            if (!en_q) begin
               ctrl_d.loop_test_select     = pwdata[POS_LOOP];
               ctrl_d.slave_txd_disable    = pwdata[POS_TXD_DIS];
               ctrl_d.transfer_mode_select = xfer_mode_t'(pwdata[POS_MODE_LO +: 2]);
            end
         end else if (paddr == ADDR_FRAME_CNT) begin
            if (!en_q) fcnt_d = pwdata[15:0];
         end else if (paddr == ADDR_ENABLE) begin
            en_d = pwdata[0];
            if (!en_q) mst_d = pwdata[POS_MASTER + 1];
         end else if (paddr == ADDR_DATA) begin
            if (tcnt_d != 3'(FIFO_DEPTH)) begin
               txf_d[tcnt_d[1:0]] = pwdata[7:0];
               tcnt_d = tcnt_d + 3'd1;
               if (st_q == ST_IDLE) rword_d = (tcnt_q == 3'd0) ? pwdata[7:0] : rword_q;
            end else begin
               perr_d = 1'b1;
            end
         end else if (paddr != ADDR_STATUS) begin
            perr_d = 1'b1;
         end
      end
      if (rd) begin
         if (paddr == ADDR_MAIN_CTRL) begin
            prd_d = {20'h0, ctrl_q.loop_test_select, ctrl_q.slave_txd_disable,
                     ctrl_q.transfer_mode_select, 8'h00};
         end else if (paddr == ADDR_FRAME_CNT) begin
            prd_d = {16'h0000, fcnt_q};
         end else if (paddr == ADDR_ENABLE) begin
            prd_d = {30'h0, mst_q, en_q};
         end else if (paddr == ADDR_STATUS) begin
            prd_d = {rxn_q, 8'h00, 3'h0, push, tcnt_q, (st_q != ST_IDLE)};
         end else begin
            prd_d  = RD_UNMAPPED;
            perr_d = 1'b1;
         end
      end
      if (!en_d) begin
         tcnt_d = 3'd0;
      end
   end

   // slave only; disable holds enable off
   assign oen_d = !(!mst_q && !ssn_s && !ctrl_q.slave_txd_disable && en_q);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // disable resets clear; mode resets 00
         ctrl_q  <= '{loop_test_select: RST_LOOP, slave_txd_disable: RST_TXD_DIS,
                      transfer_mode_select: MODE_TXRX};
         fcnt_q  <= RST_FRAME_CNT;
         en_q    <= 1'b0;
         mst_q   <= 1'b0;
         txf_q   <= '{default: 8'h00};
         tcnt_q  <= 3'd0;
         rword_q <= 8'h00;
         sh_tx_q <= 8'h00;
         sh_rx_q <= 8'h00;
         bit_q   <= 3'd0;
         rxn_q   <= 16'h0000;
         div_q   <= 8'h00;
         sck_q   <= 1'b0;
         ssn_q   <= 1'b1;
         oen_q   <= 1'b1;
         ctlf_q  <= 1'b0;
         st_q    <= ST_IDLE;
         buf_q   <= '{default: 8'h00};
         bcnt_q  <= 2'd0;
         prd_q   <= 32'h0000_0000;
         prdy_q  <= 1'b0;
         perr_q  <= 1'b0;
      end else begin
         ctrl_q  <= ctrl_d;
         fcnt_q  <= fcnt_d;
         en_q    <= en_d;
         mst_q   <= mst_d;
         txf_q   <= txf_d;
         tcnt_q  <= tcnt_d;
         rword_q <= rword_d;
         sh_tx_q <= sh_tx_d;
         sh_rx_q <= sh_rx_d;
         bit_q   <= bit_d;
         rxn_q   <= rxn_d;
         div_q   <= div_d;
         sck_q   <= sck_d;
         ssn_q   <= ssn_d;
         oen_q   <= oen_d;
         ctlf_q  <= ctlf_d;
         st_q    <= st_d;
         buf_q   <= buf_d;
         bcnt_q  <= bcnt_d;
         prd_q   <= prd_d;
         prdy_q  <= prdy_d;
         perr_q  <= perr_d;
      end
   end

   // Outputs straight from flops except rx_valid, decoded from bcnt_q
   assign prdata   = prd_q;
   assign pready   = prdy_q;
   assign pslverr  = perr_q;
   assign sclk_out = sck_q;
   assign ss_out_n = ssn_q;
   assign txd      = sh_tx_q[7];
   assign txd_oe_n = oen_q;
   assign rx_data  = buf_q[0];
   assign rx_valid = (bcnt_q != 2'd0);

endmodule : spi_transfer_mode_control

// ===== testbench/spi_peer_model.sv
`timescale 1ns/1ps
module spi_peer_model (
   // Serial pins
   input  wire logic       sclk,
   input  wire logic       ss_n,
   input  wire logic       mosi,
   output logic            miso,
   // Bench side
   input  wire logic [7:0] reply,
   output logic [7:0]      got,
   output int              frames
);
   logic [7:0] sh_in;   // Captured bits
   logic [7:0] sh_out;  // Reply bits
   int         bitc;    // Bit position in frame

   initial begin
      miso   = 1'b0;
      got    = 8'h00;
      frames = 0;
      bitc   = 0;
   end
   // Sample on rising edge, mode 0
   always @(posedge sclk) if (!ss_n) begin
      sh_in = {sh_in[6:0], mosi};
      bitc++;
      if (bitc == 8) begin
         got = sh_in;
         frames++;
         bitc = 0;
      end
   end
   always @(negedge ss_n) begin
      sh_out = reply;
      bitc   = 0;
      miso   = reply[7];
   end
   // Next bit after falling edge; reload between frames
   always @(negedge sclk) if (!ss_n) begin
      sh_out = (bitc == 0) ? reply : {sh_out[6:0], 1'b0};
      miso   = sh_out[7];
   end
   // Released line shows no stale value
   always @(posedge ss_n) miso = ~miso;
endmodule : spi_peer_model

// ===== testbench/spi_transfer_mode_control_sva.sv
`timescale 1ns/1ps
module spi_mode_sva
   import spi_mode_pkg::*;
(
   // APB side
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Serial pins
   input wire logic        sclk_in,
   input wire logic        ss_in_n,
   input wire logic        rxd,
   input wire logic        sclk_out,
   input wire logic        ss_out_n,
   input wire logic        txd,
   input wire logic        txd_oe_n,
   // Received stream
   input wire logic [7:0]  rx_data,
   input wire logic        rx_valid,
   input wire logic        rx_ready
);
   // ------------------------------------------------------------
   // Shadow of the locked fields, rebuilt from bus writes
   // ------------------------------------------------------------
   logic       en_q;   // Controller enabled
   logic       mst_q;  // Master role
   logic [3:0] ctl_q;  // Loop, disable, mode
   wire        wr_ok = psel & penable & pready & pwrite & ~pslverr;

   // Role and control only move while disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q  <= 1'b0;
         mst_q <= 1'b0;
         ctl_q <= 4'h0;
      end else if (wr_ok) begin
         if (paddr == ADDR_ENABLE) begin
            en_q <= pwdata[0];
            if (!en_q) mst_q <= pwdata[1];
         end
         if (paddr == ADDR_MAIN_CTRL && !en_q) ctl_q <= pwdata[11:8];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   wait_one_a: assert property (psel && penable && !pready |=> pready)
      else $error("pready not one cycle after access");
   pulse_one_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   unmapped_a: assert property (pready && paddr > ADDR_STATUS
      |-> pslverr && (pwrite || prdata == RD_UNMAPPED))
      else $error("unmapped access not refused");
   ctrl_read_a: assert property (
      pready && !pwrite && paddr == ADDR_MAIN_CTRL |-> prdata[11:8] == ctl_q)
      else $error("control readback wrong");
   txd_off_a: assert property (ctl_q[2] |-> txd_oe_n)
      else $error("txd driven while disabled");
   master_oe_a: assert property (mst_q && en_q |-> txd_oe_n)
      else $error("output enable active in master role");
   slave_idle_a: assert property (!mst_q |-> ss_out_n && !sclk_out)
      else $error("slave drives master pins");
   rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("rx word lost under stall");

   cover property (wr_ok && paddr == ADDR_DATA);
   cover property (rx_valid && !rx_ready);
   cover property (!txd_oe_n);
endmodule : spi_mode_sva

bind spi_transfer_mode_control spi_mode_sva i_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_in(sclk_in),
   .ss_in_n(ss_in_n), .rxd(rxd), .sclk_out(sclk_out), .ss_out_n(ss_out_n), .txd(txd),
   .txd_oe_n(txd_oe_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));

// ===== testbench/spi_transfer_mode_control_tb_top.sv
`timescale 1ns/1ps
module spi_transfer_mode_control_tb_top
   import spi_mode_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, rx_data, reply, got;
   logic [31:0] pwdata, prdata;
   logic        sclk_in, ss_in_n, rxd, rxd_tb, rxd_pm, slv, rx_ready, rx_valid;
   logic        sclk_out, ss_out_n, txd, txd_oe_n;
   int          frames, errors, comparisons, oe_low;
   logic [7:0]  rxq[$];  // Accepted rx words

   // Bench drives rxd only in slave role
   assign rxd = slv ? rxd_tb : rxd_pm;

   spi_transfer_mode_control i_spi_transfer_mode_control (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_in(sclk_in),
      .ss_in_n(ss_in_n), .rxd(rxd), .sclk_out(sclk_out), .ss_out_n(ss_out_n), .txd(txd),
      .txd_oe_n(txd_oe_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
   spi_peer_model i_spi_peer_model (.sclk(sclk_out), .ss_n(ss_out_n), .mosi(txd),
      .miso(rxd_pm), .reply(reply), .got(got), .frames(frames));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) if (rx_valid === 1'b1 && rx_ready) rxq.push_back(rx_data);
   always @(posedge pclk) if (!ss_in_n && txd_oe_n === 1'b0) oe_low++;

   task give_verdict;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // One APB transfer, entered just after a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int n;
      begin
         n = 0;
         psel   <= 1'b1;
         pwrite <= w;
         paddr  <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         do begin
            @(posedge pclk);
            n++;
         end while (pready !== 1'b1 && n < 100);
         if (pready !== 1'b1) errors++;
         r = prdata;
         e = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask : rd
   // Locked fields are set while disabled
   task cfg(input logic [3:0] c, input logic [15:0] nf, input logic [1:0] en);
      wr(ADDR_ENABLE, 32'h0);
      wr(ADDR_MAIN_CTRL, {20'h0, c, 8'h0});
      wr(ADDR_FRAME_CNT, {16'h0, nf});
      wr(ADDR_ENABLE, {30'h0, en});
      rxq.delete();
   endtask : cfg
   task idle;
      logic [31:0] s;
      int          n;
      begin
         n = 0;
         do begin
            rd(ADDR_STATUS, s);
            n++;
         end while (s[3:0] !== 4'h0 && n < 500);
         if (s[3:0] !== 4'h0) errors++;
         repeat (30) @(posedge pclk);
      end
   endtask : idle
   // External master frame, 320 ns serial clock
   task sframe(input logic [7:0] b);
      oe_low  = 0;
      slv     <= 1'b1;
      ss_in_n <= 1'b0;
      repeat (4) @(posedge pclk);
      for (int i = 7; i >= 0; i--) begin
         rxd_tb <= b[i];
         repeat (4) @(posedge pclk);
         sclk_in <= 1'b1;
         repeat (4) @(posedge pclk);
         sclk_in <= 1'b0;
      end
      repeat (4) @(posedge pclk);
      ss_in_n <= 1'b1;
      repeat (30) @(posedge pclk);
      slv <= 1'b0;
   endtask : sframe

   task t_reset;
      logic [31:0] r;
      logic        e;
      begin
         rd(ADDR_MAIN_CTRL, r);
         chk("ctrl_reset", 32'h0, {20'h0, r[11:8], 8'h0});
         rd(ADDR_FRAME_CNT, r);
         chk("frame_cnt_reset", 32'h0, {16'h0, r[15:0]});
         apb(1'b0, 8'h40, 32'h0, r, e);
         chk("unmapped", {RD_UNMAPPED[30:0], 1'b1}, {r[30:0], e});
      end
   endtask : t_reset
   task t_txrx;
      logic [31:0] r;
      int          f0;
      begin
         cfg(4'h0, 16'h0, 2'b11);
         f0 = frames;
         rx_ready <= 1'b0;
         wr(ADDR_DATA, 32'h0000_0012);
         wr(ADDR_DATA, 32'h0000_0034);
         wr(ADDR_MAIN_CTRL, 32'h0000_0100);
         rd(ADDR_MAIN_CTRL, r);
         chk("ctrl_locked", 32'h0, {28'h0, r[11:8]});
         idle;
         chk("rx_stalled", 32'h0, rxq.size());
         rx_ready <= 1'b1;
         repeat (8) @(posedge pclk);
         chk("rx_count", 32'h2, rxq.size());
         chk("rx_first", 32'hA5, rxq[0]);
         chk("rx_second", 32'hA5, rxq[1]);
         chk("frames", 32'h2, frames - f0);
         chk("peer_got", 32'h34, got);
      end
   endtask : t_txrx
   task t_txonly;
      cfg(4'h1, 16'h0, 2'b11);
      wr(ADDR_DATA, 32'h0000_005A);
      idle;
      chk("rx_dropped", 32'h0, rxq.size());
      chk("peer_got", 32'h5A, got);
   endtask : t_txonly
   task t_rxonly;
      int f0;
      begin
         cfg(4'h2, 16'h2, 2'b11);
         f0 = frames;
         wr(ADDR_DATA, 32'h0000_0066);
         idle;
         chk("rx_count", 32'h3, rxq.size());
         chk("frames", 32'h3, frames - f0);
         chk("resent", 32'h66, got);
      end
   endtask : t_rxonly
   task t_eep;
      int f0;
      begin
         cfg(4'h3, 16'h1, 2'b11);
         f0 = frames;
         wr(ADDR_DATA, 32'h0000_00A0);
         wr(ADDR_DATA, 32'h0000_0001);
         idle;
         chk("rx_count", 32'h2, rxq.size());
         chk("frames", 32'h4, frames - f0);
      end
   endtask : t_eep
   task t_loop;
      cfg(4'h8, 16'h0, 2'b11);
      wr(ADDR_DATA, 32'h0000_0081);
      idle;
      chk("rx_count", 32'h1, rxq.size());
      chk("loop_word", 32'h81, rxq[0]);
   endtask : t_loop
   task t_slave;
      cfg(4'h4, 16'h0, 2'b01);
      sframe(8'h3C);
      chk("oe_disabled", 32'h0, oe_low);
      chk("rx_count", 32'h1, rxq.size());
      chk("slave_word", 32'h3C, rxq[0]);
      cfg(4'h0, 16'h0, 2'b01);
      sframe(8'hC3);
      chk("oe_enabled", 32'h1, oe_low > 0);
   endtask : t_slave

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, sclk_in, rxd_tb, slv} = 6'h0;
      paddr    = 8'h00;
      pwdata   = 32'h0;
      ss_in_n  = 1'b1;
      rx_ready = 1'b1;
      reply    = 8'hA5;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_txrx;
      t_txonly;
      t_rxonly;
      t_eep;
      t_loop;
      t_slave;
      give_verdict;
   end
   initial begin
      #2_000_000;
      errors++;
      give_verdict;
   end
endmodule : spi_transfer_mode_control_tb_top
